/* File: hdl/ssrs_pkg.sv */
/*
 Shared constants for the synchronous serial receive and slave block:
 device register map, field positions, reset values, link framing,
 and the register map of the peer end.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package ssrs_pkg;

  // ******************************************************************
  // Device register map (bank selects between overlapping offsets)
  // ******************************************************************
  localparam logic [7:0] OFS_RX_STATUS_CONTROL = 8'h13;
  localparam logic [7:0] OFS_RX_DATA_BUFFER = 8'h14;
  localparam logic [7:0] OFS_TX_STATUS_CONTROL = 8'h15;
  localparam logic [7:0] OFS_TX_DATA_BUFFER = 8'h16;
  localparam logic [7:0] OFS_PERIPHERAL_IRQ_FLAGS = 8'h16;
  localparam logic [7:0] OFS_BAUD_DIVISOR = 8'h17;
  localparam logic [7:0] OFS_PERIPHERAL_IRQ_ENABLES = 8'h17;
  localparam logic BANK_0 = 1'b0;
  localparam logic BANK_1 = 1'b1;

  // ******************************************************************
  // Field positions
  // ******************************************************************
  localparam int RX_SERIAL_PORT_ENABLE = 7;
  localparam int RX_NINE_BIT_SELECT = 6;
  localparam int RX_SINGLE_WORD_ENABLE = 5;
  localparam int RX_CONTINUOUS_ENABLE = 4;
  localparam int RX_FRAMING_ERROR = 2;
  localparam int RX_OVERRUN = 1;
  localparam int RX_NINTH_BIT = 0;
  localparam int TX_CLOCK_SOURCE_SELECT = 7;
  localparam int TX_NINE_BIT_SELECT = 6;
  localparam int TX_TRANSMIT_ENABLE = 5;
  localparam int TX_SYNC_MODE_SELECT = 4;
  localparam int TX_SHIFT_EMPTY = 1;
  localparam int TX_NINTH_BIT = 0;
  localparam int IRQ_TX_EMPTY = 1;
  localparam int IRQ_RX_DONE = 0;

  // ******************************************************************
  // Reset values and constants
  // ******************************************************************
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] RST_PERIPHERAL_IRQ_FLAGS = 8'h02;
  localparam logic [15:0] IRQ_VECTOR = 16'h0020;
  localparam logic [15:0] NO_VECTOR = 16'h0000;
  localparam logic [3:0] LAST_BIT_8 = 4'h7;
  localparam logic [3:0] LAST_BIT_9 = 4'h8;
  localparam logic [3:0] FRAME_BITS_8 = 4'h8;
  localparam logic [3:0] FRAME_BITS_9 = 4'h9;
  localparam logic [1:0] FIFO_DEPTH = 2'h2;

  // ******************************************************************
  // Peer register map (AHB-Lite byte addresses)
  // ******************************************************************
  localparam logic [7:0] PEER_CTRL = 8'h00;
  localparam logic [7:0] PEER_DIVIDER = 8'h04;
  localparam logic [7:0] PEER_TX_WORD = 8'h08;
  localparam logic [7:0] PEER_RX_WORD = 8'h0C;
  localparam logic [7:0] PEER_STATUS = 8'h10;
  localparam int PEER_GEN_CLOCK = 0;
  localparam int PEER_SEND_ENABLE = 1;
  localparam int PEER_NINE_BIT = 2;
  localparam logic [31:0] AHB_ZERO = 32'h0000_0000;

endpackage : ssrs_pkg

/* File: hdl/ssrs_link_if.sv */
/*
 Link between the device end and the peer end: shift clock line and
 serial data line, each with per-end output and enable.
 Assumes at most one end enables each line; an undriven line reads low.
*/
`timescale 1ns/10ps
interface ssrs_link_if;
  logic devClkOut;
  logic devClkOe;
  logic devDataOut;
  logic devDataOe;
  logic peerClkOut;
  logic peerClkOe;
  logic peerDataOut;
  logic peerDataOe;
  logic shiftClk;
  logic serialData;

  // Resolved line levels
  assign shiftClk = devClkOe ? devClkOut : (peerClkOe ? peerClkOut : 1'b0);
  assign serialData = devDataOe ? devDataOut : (peerDataOe ? peerDataOut : 1'b0);

  modport device (
    output devClkOut,
    output devClkOe,
    output devDataOut,
    output devDataOe,
    input shiftClk,
    input serialData
  );

  modport peer (
    output peerClkOut,
    output peerClkOe,
    output peerDataOut,
    output peerDataOe,
    input shiftClk,
    input serialData
  );
endinterface : ssrs_link_if

/* File: hdl/ssrs_device.sv */
/*
 Device end: synchronous serial port, master and slave, receive path with
 a two-deep buffer, transmit buffer and shift register, register port.
 Assumes a single-cycle register port on sys_clk and link lines that are
 asynchronous to sys_clk.
*/
// A simple single-cycle register port was chosen for this implementation; only the peer end uses AHB-Lite.
`timescale 1ns/10ps

// Notes on behaviour
// - Either receive enable starts master reception
// - Sample data on shift clock falling edge
// - Single enable one word; continuous wins
// - Last bit moves word to buffer, flags done
// - Done flag set regardless of enable, hardware cleared
// - Receive buffer is two-deep in-order FIFO
// - Full buffer at last bit sets overrun
// - Overrun blocks transfers; cleared by continuous off
// - Ninth bit and error buffered per word
// - Enables off reset receive logic
// - Software programs divisor, mode, then enable
// - Source select clear takes external shift clock
// - Slave keeps shifting during sleep
// - Second queued word keeps empty flag clear
// - Transmit empty with enable wakes, vectors
// - Slave ignores single-word receive enable
// - Slave receives in sleep, flags, wakes
// - Slave abort resets receive logic
// - Software sets up slave transmit sequence
// - Sync mode and port enable claim pins
// - Half duplex: reception inhibits transmission
// - Master drives shift clock from generator
// - Generator held reset with all enables clear
module ssrs_device (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic clkEn,
  ssrs_link_if.device link,
  input wire logic [7:0] regAddr,
  input wire logic regBank,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  input wire logic sleepMode,
  input wire logic globalIrqEn,
  output logic rxIrq,
  output logic txIrq,
  output logic wakeUp,
  output logic [15:0] vectorAddr
);

  // ******************************************************************
  // Registers
  // ******************************************************************
  logic [7:0] rxStatusControl;
  logic [7:0] txStatusControl;
  logic [7:0] baudDivisor;
  logic [7:0] peripheralIrqEnables;
  logic overrunFlag;

  wire serialPortEnable = rxStatusControl[ssrs_pkg::RX_SERIAL_PORT_ENABLE];
  wire rxNineBitSelect = rxStatusControl[ssrs_pkg::RX_NINE_BIT_SELECT];
  wire singleWordRxEnable = rxStatusControl[ssrs_pkg::RX_SINGLE_WORD_ENABLE];
  wire continuousRxEnable = rxStatusControl[ssrs_pkg::RX_CONTINUOUS_ENABLE];
  wire clockSourceSelect = txStatusControl[ssrs_pkg::TX_CLOCK_SOURCE_SELECT];
  wire txNineBitSelect = txStatusControl[ssrs_pkg::TX_NINE_BIT_SELECT];
  wire transmitEnable = txStatusControl[ssrs_pkg::TX_TRANSMIT_ENABLE];
  wire syncMode = txStatusControl[ssrs_pkg::TX_SYNC_MODE_SELECT];
  wire txNinthBit = txStatusControl[ssrs_pkg::TX_NINTH_BIT];
  wire rxIrqEnable = peripheralIrqEnables[ssrs_pkg::IRQ_RX_DONE];
  wire txIrqEnable = peripheralIrqEnables[ssrs_pkg::IRQ_TX_EMPTY];

  wire portOn = serialPortEnable & syncMode;
  // Slave mode drops the single-word enable entirely
  wire rxOn = portOn & (continuousRxEnable | (clockSourceSelect & singleWordRxEnable));
  wire txOn = portOn & transmitEnable;
  wire txLive = txOn & ~rxOn;

  wire selRcsta = (regAddr == ssrs_pkg::OFS_RX_STATUS_CONTROL) & (regBank == ssrs_pkg::BANK_0);
  wire selRcreg = (regAddr == ssrs_pkg::OFS_RX_DATA_BUFFER) & (regBank == ssrs_pkg::BANK_0);
  wire selTxsta = (regAddr == ssrs_pkg::OFS_TX_STATUS_CONTROL) & (regBank == ssrs_pkg::BANK_0);
  wire selTxreg = (regAddr == ssrs_pkg::OFS_TX_DATA_BUFFER) & (regBank == ssrs_pkg::BANK_0);
  wire selPir = (regAddr == ssrs_pkg::OFS_PERIPHERAL_IRQ_FLAGS) & (regBank == ssrs_pkg::BANK_1);
  wire selBaud = (regAddr == ssrs_pkg::OFS_BAUD_DIVISOR) & (regBank == ssrs_pkg::BANK_0);
  wire selPie = (regAddr == ssrs_pkg::OFS_PERIPHERAL_IRQ_ENABLES) & (regBank == ssrs_pkg::BANK_1);

  // ******************************************************************
  // Pin synchronisers and shift clock edges
  // ******************************************************************
  logic clkSync1;
  logic clkSync2;
  logic clkSync3;
  logic dataSync1;
  logic dataSync2;
  logic [7:0] baudCnt;
  logic masterClk;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      {clkSync1, clkSync2, clkSync3, dataSync1, dataSync2} <= 5'h00;
    end else if (clkEn) begin
      {clkSync1, clkSync2, clkSync3} <= {link.shiftClk, clkSync1, clkSync2};
      {dataSync1, dataSync2} <= {link.serialData, dataSync1};
    end
  end

  // Core clock stops in sleep, so only the slave keeps its edges there
  wire baudRun = portOn & clockSourceSelect & ~sleepMode
                 & (transmitEnable | continuousRxEnable | singleWordRxEnable);
  wire baudHit = baudRun & (baudCnt == baudDivisor);

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      baudCnt <= ssrs_pkg::RST_BYTE;
      masterClk <= 1'b0;
    end else if (clkEn) begin
      if (!baudRun) begin
        baudCnt <= ssrs_pkg::RST_BYTE;
        masterClk <= 1'b0;
      end else if (baudHit) begin
        baudCnt <= ssrs_pkg::RST_BYTE;
        masterClk <= ~masterClk;
      end else begin
        baudCnt <= baudCnt + 8'h01;
      end
    end
  end

  wire slaveRise = clkSync2 & ~clkSync3;
  wire slaveFall = ~clkSync2 & clkSync3;
  wire riseEdge = clockSourceSelect ? (baudHit & ~masterClk) : slaveRise;
  wire fallEdge = clockSourceSelect ? (baudHit & masterClk) : slaveFall;

  // ******************************************************************
  // Receive shift register and two-deep buffer
  // ******************************************************************
  logic [8:0] rxShiftRegister;
  logic [3:0] rxBitCnt;
  logic [9:0] rxFifo [2];
  logic rxWrPtr;
  logic rxRdPtr;
  logic [1:0] rxCount;

  wire [3:0] rxLastBit = rxNineBitSelect ? ssrs_pkg::LAST_BIT_9 : ssrs_pkg::LAST_BIT_8;
  wire wordDone = rxOn & fallEdge & (rxBitCnt == rxLastBit);
  wire [7:0] newData = rxNineBitSelect ? rxShiftRegister[7:0]
                                       : {dataSync2, rxShiftRegister[6:0]};
  wire newNinth = rxNineBitSelect & dataSync2;
  // Synchronous frames carry no stop bit, so the stored error is always clear
  wire [9:0] newEntry = {1'b0, newNinth, newData};
  wire rxPush = wordDone & ~overrunFlag & (rxCount != ssrs_pkg::FIFO_DEPTH);
  wire overrunHit = wordDone & ~overrunFlag & (rxCount == ssrs_pkg::FIFO_DEPTH);
  wire rxPop = regRead & selRcreg & (rxCount != 2'h0);
  wire [9:0] rxHead = rxFifo[rxRdPtr];
  wire rxDoneFlag = (rxCount != 2'h0);
  wire singleDone = wordDone & clockSourceSelect & ~continuousRxEnable;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rxBitCnt <= 4'h0;
      rxShiftRegister <= 9'h000;
    end else if (clkEn) begin
      if (!rxOn) begin
        rxBitCnt <= 4'h0;
        rxShiftRegister <= 9'h000;
      end else if (fallEdge) begin
        rxShiftRegister[rxBitCnt] <= dataSync2;
        rxBitCnt <= wordDone ? 4'h0 : rxBitCnt + 4'h1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rxFifo[0] <= 10'h000;
      rxFifo[1] <= 10'h000;
      rxWrPtr <= 1'b0;
      rxRdPtr <= 1'b0;
      rxCount <= 2'h0;
    end else if (clkEn) begin
      if (rxPush) begin
        rxFifo[rxWrPtr] <= newEntry;
        rxWrPtr <= ~rxWrPtr;
      end
      if (rxPop) begin
        rxRdPtr <= ~rxRdPtr;
      end
      rxCount <= rxCount + {1'b0, rxPush} - {1'b0, rxPop};
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      overrunFlag <= 1'b0;
    end else if (clkEn) begin
      if (overrunHit) begin
        overrunFlag <= 1'b1;
      end else if (!continuousRxEnable) begin
        overrunFlag <= 1'b0;
      end
    end
  end

  // ******************************************************************
  // Transmit buffer and shift register
  // ******************************************************************
  logic [7:0] txDataBuffer;
  logic txBufFull;
  logic [8:0] txShiftRegister;
  logic txShiftFull;
  logic [3:0] txBitCnt;
  logic dataOut;

  wire txregWrite = regWrite & selTxreg;
  wire txLoad = txLive & txBufFull & ~txShiftFull;
  wire [3:0] txFrameBits = txNineBitSelect ? ssrs_pkg::FRAME_BITS_9 : ssrs_pkg::FRAME_BITS_8;
  wire txEmptyFlag = ~txBufFull;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      txDataBuffer <= ssrs_pkg::RST_BYTE;
      txBufFull <= 1'b0;
    end else if (clkEn) begin
      if (txregWrite) begin
        txDataBuffer <= regWdata;
        txBufFull <= 1'b1;
      end else if (txLoad) begin
        txBufFull <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      txShiftRegister <= 9'h000;
      txShiftFull <= 1'b0;
      txBitCnt <= 4'h0;
      dataOut <= 1'b0;
    end else if (clkEn) begin
      if (!txOn) begin
        txShiftFull <= 1'b0;
        txBitCnt <= 4'h0;
      end else if (txLoad) begin
        // Ninth bit is taken as it stands at the moment of transfer
        txShiftRegister <= {txNinthBit, txDataBuffer};
        txShiftFull <= 1'b1;
        txBitCnt <= 4'h0;
      end else if (txLive & txShiftFull & riseEdge) begin
        dataOut <= txShiftRegister[txBitCnt];
        txBitCnt <= txBitCnt + 4'h1;
      end else if (txLive & txShiftFull & fallEdge & (txBitCnt == txFrameBits)) begin
        txShiftFull <= 1'b0;
        txBitCnt <= 4'h0;
      end
    end
  end

  // ******************************************************************
  // Register port
  // ******************************************************************
  wire [7:0] rcstaRead = {rxStatusControl[7:4], 1'b0, rxHead[9], overrunFlag, rxHead[8]};
  wire [7:0] txstaRead = {txStatusControl[7:4], 2'b00, ~txShiftFull, txNinthBit};
  wire [7:0] pirRead = {6'h00, txEmptyFlag, rxDoneFlag};
  wire [7:0] rdMux = selRcsta ? rcstaRead :
                     selRcreg ? rxHead[7:0] :
                     selTxsta ? txstaRead :
                     selTxreg ? txDataBuffer :
                     selPir ? pirRead :
                     selBaud ? baudDivisor :
                     selPie ? peripheralIrqEnables : ssrs_pkg::RST_BYTE;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rxStatusControl <= ssrs_pkg::RST_BYTE;
      txStatusControl <= ssrs_pkg::RST_BYTE;
      baudDivisor <= ssrs_pkg::RST_BYTE;
      peripheralIrqEnables <= ssrs_pkg::RST_BYTE;
      regRdata <= ssrs_pkg::RST_BYTE;
    end else if (clkEn) begin
      if (regWrite & selRcsta) begin
        rxStatusControl <= {regWdata[7:4], 4'h0};
      end else if (singleDone) begin
        rxStatusControl[ssrs_pkg::RX_SINGLE_WORD_ENABLE] <= 1'b0;
      end
      if (regWrite & selTxsta) begin
        txStatusControl <= {regWdata[7:4], 3'h0, regWdata[0]};
      end
      if (regWrite & selBaud) begin
        baudDivisor <= regWdata;
      end
      if (regWrite & selPie) begin
        peripheralIrqEnables <= {6'h00, regWdata[1:0]};
      end
      if (regRead) begin
        regRdata <= rdMux;
      end
    end
  end

  // ******************************************************************
  // Events, wake and vector
  // ******************************************************************
  assign rxIrq = rxDoneFlag & rxIrqEnable;
  assign txIrq = txEmptyFlag & txIrqEnable;
  assign wakeUp = sleepMode & (rxIrq | txIrq);

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      vectorAddr <= ssrs_pkg::NO_VECTOR;
    end else if (clkEn) begin
      vectorAddr <= (globalIrqEn & (rxIrq | txIrq)) ? ssrs_pkg::IRQ_VECTOR
                                                     : ssrs_pkg::NO_VECTOR;
    end
  end

  assign link.devClkOut = masterClk;
  assign link.devClkOe = portOn & clockSourceSelect;
  assign link.devDataOut = dataOut;
  assign link.devDataOe = txLive;

endmodule : ssrs_device

/* File: hdl/ssrs_peer.sv */
/*
 Peer end: external synchronous serial partner, commanded over AHB-Lite.
 It either makes the shift clock by a divider or follows the device's,
 sends a word on rising edges and captures one on falling edges.
 Assumes a single AHB-Lite slave on sys_clk, zero wait states.
*/
`timescale 1ns/10ps
module ssrs_peer (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic clkEn,
  ssrs_link_if.peer link,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp
);

  // ******************************************************************
  // AHB-Lite slave
  // ******************************************************************
  logic [2:0] ctrl;
  logic [7:0] divider;
  logic [8:0] txWord;
  logic [8:0] rxWord;
  logic rxValid;
  logic dpWrite;
  logic [7:0] dpAddr;

  wire addrPhase = hsel & htrans[1] & hready;
  wire rdRxWord = addrPhase & ~hwrite & (haddr[7:0] == ssrs_pkg::PEER_RX_WORD);
  wire [31:0] rdMux = (haddr[7:0] == ssrs_pkg::PEER_CTRL) ? {29'h0, ctrl} :
                      (haddr[7:0] == ssrs_pkg::PEER_DIVIDER) ? {24'h0, divider} :
                      (haddr[7:0] == ssrs_pkg::PEER_TX_WORD) ? {23'h0, txWord} :
                      (haddr[7:0] == ssrs_pkg::PEER_RX_WORD) ? {23'h0, rxWord} :
                      (haddr[7:0] == ssrs_pkg::PEER_STATUS) ? {31'h0, rxValid} :
                      ssrs_pkg::AHB_ZERO;
  wire ctrlWrite = dpWrite & (dpAddr == ssrs_pkg::PEER_CTRL);

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      dpWrite <= 1'b0;
      dpAddr <= 8'h00;
      hrdata <= ssrs_pkg::AHB_ZERO;
    end else if (clkEn) begin
      dpWrite <= addrPhase & hwrite;
      if (addrPhase) begin
        dpAddr <= haddr[7:0];
      end
      if (addrPhase & ~hwrite) begin
        hrdata <= rdMux;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl <= 3'h0;
      divider <= 8'h00;
      txWord <= 9'h000;
    end else if (clkEn) begin
      if (ctrlWrite) begin
        ctrl <= hwdata[2:0];
      end
      if (dpWrite & (dpAddr == ssrs_pkg::PEER_DIVIDER)) begin
        divider <= hwdata[7:0];
      end
      if (dpWrite & (dpAddr == ssrs_pkg::PEER_TX_WORD)) begin
        txWord <= hwdata[8:0];
      end
    end
  end

  // ******************************************************************
  // Link side
  // ******************************************************************
  logic clkSync1;
  logic clkSync2;
  logic clkSync3;
  logic dataSync1;
  logic dataSync2;
  logic [7:0] divCnt;
  logic genClk;
  logic [3:0] bitCnt;
  logic [8:0] rxShift;
  logic dataOut;

  wire genOn = ctrl[ssrs_pkg::PEER_GEN_CLOCK];
  wire divHit = genOn & (divCnt == divider);
  wire riseEdge = genOn ? (divHit & ~genClk) : (clkSync2 & ~clkSync3);
  wire fallEdge = genOn ? (divHit & genClk) : (~clkSync2 & clkSync3);
  wire [3:0] lastBit = ctrl[ssrs_pkg::PEER_NINE_BIT] ? ssrs_pkg::LAST_BIT_9
                                                      : ssrs_pkg::LAST_BIT_8;
  wire frameDone = fallEdge & (bitCnt == lastBit);

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      {clkSync1, clkSync2, clkSync3, dataSync1, dataSync2} <= 5'h00;
      divCnt <= 8'h00;
      genClk <= 1'b0;
    end else if (clkEn) begin
      {clkSync1, clkSync2, clkSync3} <= {link.shiftClk, clkSync1, clkSync2};
      {dataSync1, dataSync2} <= {link.serialData, dataSync1};
      if (!genOn) begin
        divCnt <= 8'h00;
        genClk <= 1'b0;
      end else if (divHit) begin
        divCnt <= 8'h00;
        genClk <= ~genClk;
      end else begin
        divCnt <= divCnt + 8'h01;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      bitCnt <= 4'h0;
      rxShift <= 9'h000;
      rxWord <= 9'h000;
      rxValid <= 1'b0;
      dataOut <= 1'b0;
    end else if (clkEn) begin
      if (ctrlWrite) begin
        bitCnt <= 4'h0;
      end else if (riseEdge) begin
        dataOut <= txWord[bitCnt];
      end else if (fallEdge) begin
        rxShift[bitCnt] <= dataSync2;
        bitCnt <= frameDone ? 4'h0 : bitCnt + 4'h1;
      end
      if (frameDone & ~ctrlWrite) begin
        rxWord <= ctrl[ssrs_pkg::PEER_NINE_BIT] ? {dataSync2, rxShift[7:0]}
                                                 : {1'b0, dataSync2, rxShift[6:0]};
      end
      // A new word wins over a read that clears the flag
      if (frameDone & ~ctrlWrite) begin
        rxValid <= 1'b1;
      end else if (rdRxWord) begin
        rxValid <= 1'b0;
      end
    end
  end

  assign link.peerClkOut = genClk;
  assign link.peerClkOe = genOn;
  assign link.peerDataOut = dataOut;
  assign link.peerDataOe = ctrl[ssrs_pkg::PEER_SEND_ENABLE];

endmodule : ssrs_peer

/* File: verif/ssrs_link_props.sv */
/*
 Link checker for the device end and the peer end.
 Assumes the bench wires it to the link interface signals.
*/
`timescale 1ns/10ps
module ssrs_link_props (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic devClkOut,
  input wire logic devClkOe,
  input wire logic devDataOut,
  input wire logic devDataOe,
  input wire logic peerClkOe,
  input wire logic peerDataOe,
  input wire logic shiftClk,
  input wire logic serialData
);
  // ****
  // Link properties
  // ****
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);
  a_clk_low_min: assert property ($fell(devClkOut) |-> !devClkOut [*5])
    else $error("Clock low too short");
  a_clk_high_max: assert property ($rose(devClkOut) |-> ##[1:12] $fell(devClkOut))
    else $error("Clock stuck high");
  a_master_clk: assert property (devClkOe |-> shiftClk == devClkOut)
    else $error("Clock line wrong");
  a_slave_clk: assert property (!(devClkOe && peerClkOe))
    else $error("Clock fight");
  a_rx_no_drive: assert property (peerDataOe |-> !devDataOe)
    else $error("Data fight");
  a_dev_data: assert property (devDataOe |-> serialData == devDataOut)
    else $error("Data line wrong");
  a_data_idle: assert property (!devDataOe && !peerDataOe |-> !serialData)
    else $error("Data idle wrong");
  a_clk_idle: assert property (!devClkOe && !peerClkOe |-> !shiftClk)
    else $error("Clock idle wrong");
  c_master: cover property ($rose(devClkOut));
  c_slave: cover property (peerClkOe && $fell(shiftClk));
  c_rx: cover property (peerDataOe && $fell(devClkOut));
endmodule : ssrs_link_props

/* File: verif/tb_top.sv */
/*
 Bench joining the device end and the peer end over the link.
 Assumes package, interface and both ends are compiled first.
*/
`timescale 1ns/10ps
module tb_top;
  // ****
  // Signals and instances
  // ****
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic regBank = 1'b0;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [7:0] regWdata = 8'h00;
  logic [7:0] regRdata;
  logic sleepMode = 1'b0;
  logic globalIrqEn = 1'b0;
  logic wakeUp;
  logic [15:0] vectorAddr;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] hwdata = 32'h0;
  logic hwrite = 1'b1;
  logic [31:0] hrdata;
  logic hreadyout;
  logic [7:0] v;
  int err_count = 0;
  int n_tests = 0;
  ssrs_link_if link ();
  always #25 sys_clk = ~sys_clk;
  ssrs_device i_ssrs_device (.sys_clk(sys_clk), .nrst(nrst), .clkEn(1'b1), .link(link),
    .regAddr(regAddr), .regBank(regBank), .regWrite(regWrite), .regRead(regRead),
    .regWdata(regWdata), .regRdata(regRdata), .sleepMode(sleepMode),
    .globalIrqEn(globalIrqEn), .rxIrq(), .txIrq(), .wakeUp(wakeUp), .vectorAddr(vectorAddr));
  ssrs_peer i_ssrs_peer (.sys_clk(sys_clk), .nrst(nrst), .clkEn(1'b1), .link(link),
    .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp());
  ssrs_link_props i_ssrs_link_props (.sys_clk(sys_clk), .nrst(nrst),
    .devClkOut(link.devClkOut), .devClkOe(link.devClkOe), .devDataOut(link.devDataOut),
    .devDataOe(link.devDataOe), .peerClkOe(link.peerClkOe), .peerDataOe(link.peerDataOe),
    .shiftClk(link.shiftClk), .serialData(link.serialData));
  // ****
  // Shared tasks
  // ****
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task conclude;
    $display("Checks %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude
  task op(input logic w, input logic [7:0] a, input logic b, input logic [7:0] d);
    regWrite <= w;
    regRead <= !w;
    regAddr <= a;
    regBank <= b;
    regWdata <= d;
    @(posedge sys_clk);
    regWrite <= 1'b0;
    regRead <= 1'b0;
    // Read data stands from the edge that took the read until the next read
    @(posedge sys_clk);
    v = regRdata;
  endtask : op
  // Waits sample at the rising edge and return on it
  task waitFor(input int sel);
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while ((sel ? wakeUp : hreadyout) !== 1'b1 && n < 400);
    if ((sel ? wakeUp : hreadyout) !== 1'b1) begin
      err_count++;
      conclude();
    end
  endtask : waitFor
  task ahb(input logic [7:0] a, input logic [7:0] d);
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    waitFor(0);
    htrans <= 2'h0;
    hwdata <= {24'h000000, d};
    waitFor(0);
  endtask : ahb
  // ****
  // Scenarios
  // ****
  task t_master;
    int n;
    op(1'b0, 8'h16, 1'b1, 8'h00);
    chk({8'h00, v}, 16'h0002);
    ahb(8'h08, 8'h4D);
    ahb(8'h00, 8'h02);
    // Divisor covers the round trip through both ends' synchronisers
    op(1'b1, 8'h17, 1'b0, 8'h05);
    op(1'b1, 8'h15, 1'b0, 8'h90);
    op(1'b1, 8'h13, 1'b0, 8'h90);
    n = 0;
    do begin
      op(1'b0, 8'h13, 1'b0, 8'h00);
      n++;
    end while (v[1] !== 1'b1 && n < 300);
    if (v[1] !== 1'b1) begin
      err_count++;
      conclude();
    end
    chk({8'h00, v}, 16'h0092);
    op(1'b0, 8'h14, 1'b0, 8'h00);
    chk({8'h00, v}, 16'h004D);
    op(1'b0, 8'h14, 1'b0, 8'h00);
    chk({8'h00, v}, 16'h004D);
    op(1'b0, 8'h16, 1'b1, 8'h00);
    chk({8'h00, v}, 16'h0002);
    op(1'b1, 8'h13, 1'b0, 8'h80);
    op(1'b0, 8'h13, 1'b0, 8'h00);
    chk({8'h00, v}, 16'h0080);
    ahb(8'h00, 8'h00);
  endtask : t_master
  task t_slave;
    sleepMode <= 1'b1;
    globalIrqEn <= 1'b1;
    op(1'b1, 8'h15, 1'b0, 8'h10);
    op(1'b1, 8'h17, 1'b1, 8'h01);
    op(1'b1, 8'h13, 1'b0, 8'hB0);
    ahb(8'h08, 8'h1E);
    ahb(8'h04, 8'h03);
    ahb(8'h00, 8'h03);
    waitFor(1);
    @(negedge sys_clk);
    chk(vectorAddr, 16'h0020);
    @(posedge sys_clk);
    ahb(8'h00, 8'h00);
    op(1'b0, 8'h14, 1'b0, 8'h00);
    chk({8'h00, v}, 16'h001E);
  endtask : t_slave
  task t_slave_tx;
    op(1'b1, 8'h13, 1'b0, 8'h80);
    op(1'b1, 8'h16, 1'b0, 8'hA5);
    op(1'b1, 8'h15, 1'b0, 8'h30);
    op(1'b1, 8'h16, 1'b0, 8'h3C);
    op(1'b0, 8'h16, 1'b1, 8'h00);
    chk({8'h00, v}, 16'h0000);
    op(1'b1, 8'h17, 1'b1, 8'h02);
    // Slower peer clock leaves room for the device's data to reach it
    ahb(8'h04, 8'h05);
    ahb(8'h00, 8'h01);
    waitFor(1);
    @(negedge sys_clk);
    chk(vectorAddr, 16'h0020);
    @(posedge sys_clk);
    hwrite <= 1'b0;
    ahb(8'h0C, 8'h00);
    hwrite <= 1'b1;
    chk({7'h00, hrdata[8:0]}, 16'h00A5);
    ahb(8'h00, 8'h00);
  endtask : t_slave_tx
  initial begin
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    t_master();
    t_slave();
    t_slave_tx();
    conclude();
  end
endmodule : tb_top
